// >>> rtl/ofd_pkg.sv
// shared constants and carrier types of the operand field decoder
package ofd_pkg;

    // ****************
    // register map
    // ****************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [15:0] CTRL_RESET = 16'h0001;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SAT_BIT = 1;
    localparam int STATUS_ILLEGAL_BIT = 0;
    localparam int STATUS_NOP_BIT = 1;
    localparam int STATUS_ACCUM_A_OVERFLOW_BIT = 4;
    localparam int STATUS_ACCUM_B_OVERFLOW_BIT = 5;
    localparam int STATUS_ACCUM_A_SATURATE_BIT = 6;
    localparam int STATUS_ACCUM_B_SATURATE_BIT = 7;

    // ****************
    // operand classes
    // ****************
    localparam logic [2:0] CLASS_GENERAL = 3'h0;
    localparam logic [2:0] CLASS_DSP_MOVE = 3'h1;
    localparam logic [2:0] CLASS_DIVIDE = 3'h2;
    localparam logic [2:0] CLASS_SQUARE = 3'h3;
    localparam logic [2:0] CLASS_MAC = 3'h4;
    localparam logic [2:0] CLASS_FILE_ADD = 3'h5;
    localparam logic [2:0] CLASS_ACC_ADD = 3'h6;

    // ****************
    // addressing modes
    // ****************
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_INDIRECT = 3'h1;
    localparam logic [2:0] MODE_POST_INC = 3'h2;
    localparam logic [2:0] MODE_POST_DEC = 3'h3;
    localparam logic [2:0] MODE_PRE_INC = 3'h4;
    localparam logic [2:0] MODE_PRE_DEC = 3'h5;
    localparam logic [2:0] MODE_REG_OFFSET = 3'h6;

    // ****************
    // fixed registers and codes
    // ****************
    localparam logic [3:0] REG_W0 = 4'h0;
    localparam logic [3:0] REG_W4 = 4'h4;
    localparam logic [3:0] REG_W8 = 4'h8;
    localparam logic [3:0] REG_W10 = 4'hA;
    localparam logic [3:0] REG_W12 = 4'hC;
    localparam logic [3:0] REG_W13 = 4'hD;
    localparam logic [3:0] PF_STEPS = 4'h7;
    localparam logic [3:0] PF_INDEXED = 4'hE;
    localparam logic [3:0] PF_NONE = 4'hF;
    localparam logic [2:0] PAIR_COUNT = 3'h6;
    localparam logic [7:0] NOP_OPCODE = 8'h00;
    localparam int ACC_W = 40;
    localparam int ACC_GUARD_MSB = 31;

    typedef struct packed {
        logic valid;
        logic [23:0] word;
        logic [2:0] op_class;
        logic [3:0] base_reg;
        logic [2:0] dest_mode;
        logic [3:0] dest_reg;
        logic [2:0] src_mode;
        logic [3:0] src_reg;
        logic [2:0] pair_sel;
        logic [3:0] x_code;
        logic [3:0] y_code;
        logic [1:0] x_dest_sel;
        logic [1:0] y_dest_sel;
        logic accum_writeback_inc;
        logic acc_sel;
    } ofd_req_type;

    typedef struct packed {
        logic en;
        logic [3:0] ptr;
        logic signed [3:0] step;
        logic indexed;
        logic [3:0] index_reg;
        logic [3:0] dest;
    } ofd_prefetch_type;

    typedef struct packed {
        logic valid;
        logic nop;
        logic illegal;
        logic [3:0] base_reg;
        logic [3:0] src_reg;
        logic [2:0] src_mode;
        logic [3:0] dst_reg;
        logic [2:0] dst_mode;
        logic [3:0] mul_a;
        logic [3:0] mul_b;
        ofd_prefetch_type x_pf;
        ofd_prefetch_type y_pf;
        logic [3:0] accum_writeback_target;
        logic accum_writeback_inc;
    } ofd_dec_type;

    typedef struct packed {
        logic c;
        logic digit_carry_flag;
        logic n;
        logic overflow_flag;
        logic z;
    } ofd_flags_type;

endpackage

// >>> rtl/ofd_decoder.sv
// operand field decoder with file-register and accumulator add paths
//
// Our own choices: the address-and-strobe port and the register offsets.
module ofd_decoder (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire ofd_pkg::ofd_req_type req,
    input wire logic [15:0] file_data,
    input wire logic [15:0] w0_data,
    input wire logic signed [39:0] acc_a,
    input wire logic signed [39:0] acc_b,
    output ofd_pkg::ofd_dec_type dec,
    output logic [15:0] add_result,
    output ofd_pkg::ofd_flags_type add_flags,
    output logic add_valid,
    output logic signed [39:0] acc_result,
    output logic acc_valid,
    output logic acc_target
);

    // ****************
    // control and status
    // ****************
    logic [15:0] ctrl;
    logic illegal_sticky;
    logic nop_sticky;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_saturate;
    logic acc_b_saturate;
    ofd_pkg::ofd_dec_type next_dec;
    logic take;

    assign take = req.valid & ctrl[ofd_pkg::CTRL_ENABLE_BIT];

    always_ff @(posedge core_clk)
    begin
        if (srst)
            ctrl <= ofd_pkg::CTRL_RESET;
        else if (reg_wr && reg_addr == ofd_pkg::ADDR_CTRL)
            ctrl <= reg_wdata;
    end

    // writing one clears; a new event in the same cycle wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            illegal_sticky <= 1'b0;
            nop_sticky <= 1'b0;
        end
        else
        begin
            if (take && next_dec.illegal)
                illegal_sticky <= 1'b1;
            else if (reg_wr && reg_addr == ofd_pkg::ADDR_STATUS
                     && reg_wdata[ofd_pkg::STATUS_ILLEGAL_BIT])
                illegal_sticky <= 1'b0;
            if (take && next_dec.nop)
                nop_sticky <= 1'b1;
            else if (reg_wr && reg_addr == ofd_pkg::ADDR_STATUS
                     && reg_wdata[ofd_pkg::STATUS_NOP_BIT])
                nop_sticky <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            reg_rdata <= 16'h0000;
        else if (reg_rd && reg_addr == ofd_pkg::ADDR_CTRL)
            reg_rdata <= ctrl;
        else if (reg_rd && reg_addr == ofd_pkg::ADDR_STATUS)
        begin
            reg_rdata <= 16'h0000;
            reg_rdata[ofd_pkg::STATUS_ILLEGAL_BIT] <= illegal_sticky;
            reg_rdata[ofd_pkg::STATUS_NOP_BIT] <= nop_sticky;
            reg_rdata[ofd_pkg::STATUS_ACCUM_A_OVERFLOW_BIT] <= acc_a_overflow;
            reg_rdata[ofd_pkg::STATUS_ACCUM_B_OVERFLOW_BIT] <= acc_b_overflow;
            reg_rdata[ofd_pkg::STATUS_ACCUM_A_SATURATE_BIT] <= acc_a_saturate;
            reg_rdata[ofd_pkg::STATUS_ACCUM_B_SATURATE_BIT] <= acc_b_saturate;
        end
        else
            reg_rdata <= 16'h0000;
    end

    // ****************
    // prefetch decode
    // ****************
    function automatic ofd_pkg::ofd_prefetch_type pf_decode(input logic [3:0] code,
                                                             input logic [3:0] ptr_lo,
                                                             input logic [1:0] dest_sel);
        ofd_pkg::ofd_prefetch_type p;
        logic [3:0] step_idx;
        p = '0;
        step_idx = (code >= ofd_pkg::PF_STEPS) ? code - ofd_pkg::PF_STEPS : code;
        p.en = (code != ofd_pkg::PF_NONE);
        p.ptr = (code >= ofd_pkg::PF_STEPS) ? ptr_lo + 4'h1 : ptr_lo;
        p.indexed = (code == ofd_pkg::PF_INDEXED);
        p.index_reg = p.indexed ? ofd_pkg::REG_W12 : 4'h0;
        p.dest = ofd_pkg::REG_W4 + {2'h0, dest_sel};
        if (p.indexed || !p.en)
            p.step = 4'sh0;
        else
        begin
            unique case (step_idx)
                4'h0: p.step = 4'sh6;
                4'h1: p.step = 4'sh4;
                4'h2: p.step = 4'sh2;
                4'h3: p.step = 4'sh0;
                4'h4: p.step = -4'sh6;
                4'h5: p.step = -4'sh4;
                default: p.step = -4'sh2;
            endcase
        end
        if (!p.en)
            p.dest = 4'h0;
        return p;
    endfunction

    // ****************
    // operand decode
    // ****************
    always_comb
    begin
        next_dec = '0;
        next_dec.valid = 1'b1;
        next_dec.nop = (req.word[23:16] == ofd_pkg::NOP_OPCODE);
        if (!next_dec.nop)
        begin
            unique case (req.op_class)
                ofd_pkg::CLASS_GENERAL:
                begin
                    next_dec.base_reg = req.base_reg;
                    next_dec.src_reg = req.src_reg;
                    next_dec.src_mode = req.src_mode;
                    next_dec.dst_reg = req.dest_reg;
                    next_dec.dst_mode = req.dest_mode;
                    next_dec.illegal = (req.dest_mode > ofd_pkg::MODE_PRE_DEC)
                                     | (req.src_mode > ofd_pkg::MODE_PRE_DEC);
                end
                ofd_pkg::CLASS_DSP_MOVE:
                begin
                    next_dec.base_reg = req.base_reg;
                    next_dec.src_reg = req.src_reg;
                    next_dec.src_mode = req.src_mode;
                    next_dec.dst_reg = req.dest_reg;
                    next_dec.dst_mode = req.dest_mode;
                    next_dec.illegal = (req.dest_mode > ofd_pkg::MODE_REG_OFFSET)
                                     | (req.src_mode > ofd_pkg::MODE_REG_OFFSET)
                                     | (req.src_mode == ofd_pkg::MODE_INDIRECT);
                end
                ofd_pkg::CLASS_DIVIDE:
                begin
                    next_dec.src_reg = req.src_reg;
                    next_dec.base_reg = req.base_reg;
                    next_dec.src_mode = ofd_pkg::MODE_DIRECT;
                    next_dec.dst_mode = ofd_pkg::MODE_DIRECT;
                end
                ofd_pkg::CLASS_SQUARE:
                begin
                    next_dec.mul_a = ofd_pkg::REG_W4 + {2'h0, req.pair_sel[1:0]};
                    next_dec.mul_b = next_dec.mul_a;
                    next_dec.illegal = req.pair_sel[2];
                end
                ofd_pkg::CLASS_MAC:
                begin
                    unique case (req.pair_sel)
                        3'h0: {next_dec.mul_a, next_dec.mul_b} = {4'h4, 4'h5};
                        3'h1: {next_dec.mul_a, next_dec.mul_b} = {4'h4, 4'h6};
                        3'h2: {next_dec.mul_a, next_dec.mul_b} = {4'h4, 4'h7};
                        3'h3: {next_dec.mul_a, next_dec.mul_b} = {4'h5, 4'h6};
                        3'h4: {next_dec.mul_a, next_dec.mul_b} = {4'h5, 4'h7};
                        3'h5: {next_dec.mul_a, next_dec.mul_b} = {4'h6, 4'h7};
                        default: {next_dec.mul_a, next_dec.mul_b} = 8'h00;
                    endcase
                    next_dec.illegal = (req.pair_sel >= ofd_pkg::PAIR_COUNT);
                    next_dec.x_pf = pf_decode(req.x_code, ofd_pkg::REG_W8,
                                              req.x_dest_sel);
                    next_dec.y_pf = pf_decode(req.y_code, ofd_pkg::REG_W10,
                                              req.y_dest_sel);
                    next_dec.accum_writeback_target = ofd_pkg::REG_W13;
                    next_dec.accum_writeback_inc = req.accum_writeback_inc;
                end
                ofd_pkg::CLASS_FILE_ADD:
                begin
                    next_dec.base_reg = ofd_pkg::REG_W0;
                    next_dec.dst_reg = ofd_pkg::REG_W0;
                    next_dec.dst_mode = ofd_pkg::MODE_DIRECT;
                end
                ofd_pkg::CLASS_ACC_ADD:
                begin
                    next_dec.accum_writeback_target = ofd_pkg::REG_W13;
                end
                default:
                    next_dec.illegal = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            dec <= '0;
        else if (take)
            dec <= next_dec;
        else
            dec.valid <= 1'b0;
    end

    // ****************
    // file-register add
    // ****************
    logic [16:0] next_sum;
    logic [4:0] next_nibble;
    logic file_go;
    logic acc_go;

    assign file_go = take && !next_dec.nop && req.op_class == ofd_pkg::CLASS_FILE_ADD;
    assign acc_go = take && !next_dec.nop && req.op_class == ofd_pkg::CLASS_ACC_ADD;
    assign next_sum = {1'b0, file_data} + {1'b0, w0_data};
    assign next_nibble = {1'b0, file_data[3:0]} + {1'b0, w0_data[3:0]};

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            add_result <= 16'h0000;
            add_flags <= '0;
            add_valid <= 1'b0;
        end
        else
        begin
            add_valid <= file_go;
            if (file_go)
            begin
                add_result <= next_sum[15:0];
                add_flags.c <= next_sum[16];
                add_flags.digit_carry_flag <= next_nibble[4];
                add_flags.n <= next_sum[15];
                add_flags.overflow_flag <= (file_data[15] == w0_data[15])
                              && (next_sum[15] != file_data[15]);
                add_flags.z <= (next_sum[15:0] == 16'h0000);
            end
        end
    end

    // ****************
    // accumulator add
    // ****************
    logic signed [40:0] next_acc_wide;
    logic next_acc_overflow;
    logic next_acc_cat;
    logic signed [39:0] next_acc;

    assign next_acc_wide = {acc_a[39], acc_a} + {acc_b[39], acc_b};
    assign next_acc_cat = next_acc_wide[40] != next_acc_wide[39];
    assign next_acc_overflow = !(&next_acc_wide[39:ofd_pkg::ACC_GUARD_MSB]
                           || ~|next_acc_wide[39:ofd_pkg::ACC_GUARD_MSB]);

    always_comb
    begin
        next_acc = next_acc_wide[39:0];
        if (next_acc_cat && ctrl[ofd_pkg::CTRL_SAT_BIT])
            next_acc = next_acc_wide[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            acc_result <= 40'sh0;
            acc_valid <= 1'b0;
            acc_target <= 1'b0;
            acc_a_overflow <= 1'b0;
            acc_b_overflow <= 1'b0;
            acc_a_saturate <= 1'b0;
            acc_b_saturate <= 1'b0;
        end
        else
        begin
            acc_valid <= acc_go;
            if (acc_go)
            begin
                acc_result <= next_acc;
                acc_target <= req.acc_sel;
                acc_a_overflow <= req.acc_sel ? acc_a_overflow : next_acc_overflow;
                acc_b_overflow <= req.acc_sel ? next_acc_overflow : acc_b_overflow;
                acc_a_saturate <= req.acc_sel ? acc_a_saturate
                                              : acc_a_saturate | next_acc_cat;
                acc_b_saturate <= req.acc_sel ? acc_b_saturate | next_acc_cat
                                              : acc_b_saturate;
            end
        end
    end

endmodule

// >>> tb/ofd_regfile_model.sv
// register file and accumulator model at the decoder's far side
module ofd_regfile_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [1:0] load_sel,
    input wire logic [39:0] load_val,
    input wire logic [15:0] add_result,
    input wire logic add_valid,
    input wire logic signed [39:0] acc_result,
    input wire logic acc_valid,
    input wire logic acc_target,
    output logic [15:0] w0_data,
    output logic [15:0] file_data,
    output logic signed [39:0] acc_a,
    output logic signed [39:0] acc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            w0_data <= 16'h0000;
            file_data <= 16'h0000;
            acc_a <= 40'h00_0000_0000;
            acc_b <= 40'h00_0000_0000;
        end
        else if (load)
        begin
            w0_data <= (load_sel == 2'h0) ? load_val[15:0] : w0_data;
            file_data <= (load_sel == 2'h1) ? load_val[15:0] : file_data;
            acc_a <= (load_sel == 2'h2) ? load_val : acc_a;
            acc_b <= (load_sel == 2'h3) ? load_val : acc_b;
        end
        else
        begin
            w0_data <= add_valid ? add_result : w0_data;
            acc_a <= (acc_valid && !acc_target) ? acc_result : acc_a;
            acc_b <= (acc_valid && acc_target) ? acc_result : acc_b;
        end
    end
endmodule

// >>> tb/ofd_decoder_properties.sv
// concurrent checks on the decoder ports
module ofd_decoder_properties (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire ofd_pkg::ofd_req_type req,
    input wire logic [15:0] file_data,
    input wire logic [15:0] w0_data,
    input wire ofd_pkg::ofd_dec_type dec,
    input wire logic [15:0] add_result,
    input wire logic add_valid,
    input wire logic acc_valid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    ofd_pkg::ofd_req_type q;
    logic ok;
    always_ff @(posedge core_clk) q <= req;
    assign ok = dec.valid && !dec.nop && !dec.illegal;
    gen_regs_a: assert property (ok && q.op_class == ofd_pkg::CLASS_GENERAL |->
        dec.src_reg == q.src_reg && dec.dst_reg == q.dest_reg) else $error("general regs");
    gen_modes_a: assert property (ok && q.op_class == ofd_pkg::CLASS_GENERAL |->
        dec.dst_mode == q.dest_mode && dec.src_mode == q.src_mode) else $error("general modes");
    dsp_dest_a: assert property (ok && q.op_class == ofd_pkg::CLASS_DSP_MOVE |->
        dec.dst_mode == q.dest_mode) else $error("dsp dest mode");
    dsp_src_a: assert property (ok && q.op_class == ofd_pkg::CLASS_DSP_MOVE |->
        dec.src_mode != ofd_pkg::MODE_INDIRECT) else $error("dsp plain indirect");
    div_direct_a: assert property (ok && q.op_class == ofd_pkg::CLASS_DIVIDE |->
        dec.src_mode == ofd_pkg::MODE_DIRECT && dec.base_reg == q.base_reg) else $error("divide");
    square_pair_a: assert property (ok && q.op_class == ofd_pkg::CLASS_SQUARE |->
        dec.mul_a == dec.mul_b && dec.mul_a == {2'b01, q.pair_sel[1:0]}) else $error("square");
    mac_pair_a: assert property (ok && q.op_class == ofd_pkg::CLASS_MAC |->
        dec.mul_a != dec.mul_b && dec.mul_a[3:2] == 2'b01 && dec.mul_b[3:2] == 2'b01)
        else $error("mac pair");
    x_pointer_a: assert property (dec.valid && dec.x_pf.en |->
        dec.x_pf.ptr[3:1] == 3'h4 && dec.x_pf.dest[3:2] == 2'b01) else $error("x prefetch");
    y_pointer_a: assert property (dec.valid && dec.y_pf.en |->
        dec.y_pf.ptr[3:1] == 3'h5 && dec.y_pf.dest[3:2] == 2'b01) else $error("y prefetch");
    x_index_a: assert property (dec.valid && dec.x_pf.indexed |->
        dec.x_pf.ptr == 4'h9 && dec.x_pf.index_reg == ofd_pkg::REG_W12) else $error("x index");
    writeback_reg_a: assert property (ok && q.op_class == ofd_pkg::CLASS_MAC |->
        dec.accum_writeback_target == ofd_pkg::REG_W13
        && dec.accum_writeback_inc == q.accum_writeback_inc) else $error("writeback reg");
    file_add_a: assert property (add_valid |-> dec.dst_reg == ofd_pkg::REG_W0 &&
        add_result == 16'($past(file_data) + $past(w0_data))) else $error("file add");
    nop_word_a: assert property (dec.valid && q.word[23:16] == 8'h00 |->
        dec.nop && !add_valid && !acc_valid) else $error("nop word");
    acc_timing_a: assert property (acc_valid |->
        dec.valid && q.op_class == ofd_pkg::CLASS_ACC_ADD) else $error("acc add timing");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data idle");
endmodule
bind ofd_decoder ofd_decoder_properties u_props (.*);

// >>> tb/operand_field_decoder_bench.sv
// self-checking bench for the operand field decoder
module operand_field_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic load = 1'b0;
    logic [1:0] load_sel = 2'h0;
    logic [39:0] load_val = 40'h00_0000_0000;
    ofd_pkg::ofd_req_type req = '0;
    logic [15:0] reg_rdata, file_data, w0_data, add_result;
    logic signed [39:0] acc_a, acc_b, acc_result;
    ofd_pkg::ofd_dec_type dec;
    ofd_pkg::ofd_flags_type add_flags;
    logic add_valid, acc_valid, acc_target;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    ofd_decoder DUT (.*);
    ofd_regfile_model PEER (.*);
    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic reg_op(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic put(input logic [1:0] s, input logic [39:0] v);
        @(posedge core_clk);
        load <= 1'b1;
        load_sel <= s;
        load_val <= v;
        @(posedge core_clk);
        load <= 1'b0;
    endtask
    task automatic send(input ofd_pkg::ofd_req_type r);
        @(posedge core_clk);
        req <= r;
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask
    function automatic ofd_pkg::ofd_req_type mk(input logic [2:0] c);
        mk = '0;
        mk.valid = 1'b1;
        mk.word = 24'h01_0000;
        mk.op_class = c;
    endfunction
    task automatic t_regs;
        reg_op(1'b0, ofd_pkg::ADDR_CTRL, 16'h0000);
        chk("ctrl", 40'h1, 40'(reg_rdata));
        reg_op(1'b0, 4'h8, 16'h0000);
        chk("unmapped", 40'h0, 40'(reg_rdata));
        reg_op(1'b1, ofd_pkg::ADDR_CTRL, 16'h0000);
        send(mk(ofd_pkg::CLASS_GENERAL));
        chk("dropped valid", 40'h0, 40'(dec.valid));
        reg_op(1'b1, ofd_pkg::ADDR_CTRL, 16'h0001);
    endtask
    task automatic t_general;
        ofd_pkg::ofd_req_type r;
        for (int i = 0; i < 16; i++)
        begin
            r = mk(ofd_pkg::CLASS_GENERAL);
            r.src_reg = 4'(i);
            r.dest_reg = 4'(15 - i);
            r.src_mode = 3'(i % 6);
            r.dest_mode = 3'(5 - i % 6);
            send(r);
            chk("src reg", 40'(i), 40'(dec.src_reg));
            chk("dst reg", 40'(15 - i), 40'(dec.dst_reg));
            chk("src mode", 40'(i % 6), 40'(dec.src_mode));
            chk("dst mode", 40'(5 - i % 6), 40'(dec.dst_mode));
        end
        r.dest_mode = ofd_pkg::MODE_REG_OFFSET;
        send(r);
        chk("gen offset illegal", 40'h1, 40'(dec.illegal));
        r = mk(ofd_pkg::CLASS_DSP_MOVE);
        r.base_reg = 4'h3;
        r.dest_mode = ofd_pkg::MODE_REG_OFFSET;
        r.src_mode = ofd_pkg::MODE_REG_OFFSET;
        send(r);
        chk("dsp dst mode", 40'h6, 40'(dec.dst_mode));
        chk("dsp src mode", 40'h6, 40'(dec.src_mode));
        r.src_mode = ofd_pkg::MODE_INDIRECT;
        send(r);
        chk("dsp indirect", 40'h1, 40'(dec.illegal));
        r = mk(ofd_pkg::CLASS_DIVIDE);
        r.src_reg = 4'h9;
        r.base_reg = 4'h2;
        send(r);
        chk("dividend", 40'h9, 40'(dec.src_reg));
        chk("divisor", 40'h2, 40'(dec.base_reg));
    endtask
    task automatic t_mul;
        ofd_pkg::ofd_req_type r;
        int pa[6] = '{4, 4, 4, 5, 5, 6};
        int pb[6] = '{5, 6, 7, 6, 7, 7};
        for (int i = 0; i < 7; i++)
        begin
            r = mk(ofd_pkg::CLASS_MAC);
            r.pair_sel = 3'(i);
            r.accum_writeback_inc = i[0];
            r.x_code = ofd_pkg::PF_NONE;
            r.y_code = ofd_pkg::PF_NONE;
            send(r);
            chk("mac illegal", 40'(i == 6), 40'(dec.illegal));
            if (i < 6)
            begin
                chk("mul a", 40'(pa[i]), 40'(dec.mul_a));
                chk("mul b", 40'(pb[i]), 40'(dec.mul_b));
                chk("writeback", {35'h0, 1'b1, 3'h5, i[0]},
                    {35'h0, dec.accum_writeback_target, dec.accum_writeback_inc});
            end
            r.op_class = ofd_pkg::CLASS_SQUARE;
            r.pair_sel = 3'(i % 5);
            send(r);
            chk("square", (i % 5 == 4) ? 40'h1 : 40'(4 + i % 5),
                (i % 5 == 4) ? 40'(dec.illegal) : 40'({dec.mul_a, dec.mul_b} / 17));
        end
    endtask
    task automatic t_prefetch;
        ofd_pkg::ofd_req_type r;
        int st[7] = '{6, 4, 2, 0, -6, -4, -2};
        int p;
        for (int c = 0; c < 16; c++)
        begin
            r = mk(ofd_pkg::CLASS_MAC);
            r.x_code = 4'(c);
            r.y_code = 4'(c);
            r.x_dest_sel = 2'(c);
            r.y_dest_sel = 2'(3 - c);
            send(r);
            p = (c == 14) ? 9 : 8 + int'(c >= 7);
            chk("x en", 40'(c != 15), 40'(dec.x_pf.en));
            chk("y indexed", 40'(c == 14), 40'(dec.y_pf.indexed));
            chk("x dest", (c == 15) ? 40'h0 : 40'(4 + c % 4), 40'(dec.x_pf.dest));
            chk("y dest", (c == 15) ? 40'h0 : 40'(7 - c % 4), 40'(dec.y_pf.dest));
            if (c < 15)
            begin
                chk("x ptr", 40'(p), 40'(dec.x_pf.ptr));
                chk("y ptr", 40'(p + 2), 40'(dec.y_pf.ptr));
            end
            if (c < 14)
                chk("y step", {36'h0, 4'(st[c % 7])}, {36'h0, dec.y_pf.step});
        end
    endtask
    task automatic t_adds;
        ofd_pkg::ofd_req_type r;
        put(2'h0, 40'h00_0000_0001);
        put(2'h1, 40'h00_0000_7FFF);
        send(mk(ofd_pkg::CLASS_FILE_ADD));
        chk("add 1", 40'h1_8000, {23'h0, add_valid, add_result});
        chk("flags 1", 40'hE, 40'(add_flags));
        chk("implicit_working_reg", 40'h0, {dec.base_reg, dec.dst_reg});
        put(2'h1, 40'h00_0000_8000);
        chk("w0 back", 40'h8000, 40'(w0_data));
        send(mk(ofd_pkg::CLASS_FILE_ADD));
        chk("add 2", 40'h1_0000, {23'h0, add_valid, add_result});
        chk("flags 2", 40'h13, 40'(add_flags));
        put(2'h2, 40'h00_4000_0000);
        put(2'h3, 40'h00_4000_0000);
        r = mk(ofd_pkg::CLASS_ACC_ADD);
        r.acc_sel = 1'b1;
        send(r);
        chk("acc valid", 40'h3, {38'h0, acc_valid, acc_target});
        chk("acc sum", 40'h00_8000_0000, acc_result);
        reg_op(1'b0, ofd_pkg::ADDR_STATUS, 16'h0000);
        chk("acc status", 40'h2, 40'(reg_rdata[7:4]));
        r.word = 24'h00_1234;
        send(r);
        chk("nop", 40'h2, {38'h0, dec.nop, acc_valid});
        reg_op(1'b0, ofd_pkg::ADDR_STATUS, 16'h0000);
        chk("sticky", 40'h3, 40'(reg_rdata[1:0]));
        reg_op(1'b1, ofd_pkg::ADDR_STATUS, 16'h0003);
        reg_op(1'b0, ofd_pkg::ADDR_STATUS, 16'h0000);
        chk("sticky clear", 40'h0, 40'(reg_rdata[1:0]));
        reg_op(1'b1, ofd_pkg::ADDR_CTRL, 16'h0003);
        put(2'h2, 40'h7F_0000_0000);
        put(2'h3, 40'h7F_0000_0000);
        r.word = 24'h01_0000;
        r.acc_sel = 1'b0;
        send(r);
        chk("acc saturated", 40'h7F_FFFF_FFFF, acc_result);
        reg_op(1'b0, ofd_pkg::ADDR_STATUS, 16'h0000);
        chk("acc sat status", 40'h7, 40'(reg_rdata[7:4]));
    endtask
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail++;
            test_done;
        end
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_regs;
        t_general;
        t_mul;
        t_prefetch;
        t_adds;
        test_done;
    end
endmodule
